/* File: rtl/clock_reset_power_modes.sv */
// Clock, reset and power-mode controller working with clock ticks on one clock.
// Overview of operation
// - Main clock from crystal or external input.
// - Main clock references two PLL multipliers.
// - Peripheral clock is core clock over 1/2/4.
// - Auxiliary clocks through 12-bit prescalers each.
// - Power Save runs core clock from slow clock.
// - Slow crystal lets fast oscillator, PLLs stop.
// - External, watchdog or debug request resets device.
// - Power-on reset holds reset long enough.
// - Four modes; Active runs fully from fast.
// - Power Save keeps CPU running at slow rate.
// - Idle stops all but power manager, watchdog.
// - Halt stops core, peripheral, auxiliary and watchdog clocks, keeps state.
// - Any enabled wake-up channel returns to Active.
// - Each channel maps to one of eight interrupts.
// - Timing and watchdog module runs on slow clock.
`timescale 1ns/1ps
`include "crpm_defs.svh"
module clock_reset_power_modes
  import crpm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic xtal_clk_pin,
  input wire logic ext_clk_pin,
  input wire logic main_src_ext,
  input wire logic x32_pin,
  input wire logic slow_src_presc,
  input wire logic [11:0] slow_ratio,
  input wire logic [1:0] hclk_src,
  input wire logic [1:0] pll_req,
  input wire logic [1:0][11:0] pll_ratio,
  input wire logic [1:0] pclk_div,
  input wire logic [1:0][1:0] aux_src,
  input wire logic [1:0][11:0] aux_ratio,
  input wire logic hf_off_req,
  input wire power_mode_e mode_req,
  input wire logic mode_req_stb,
  input wire logic [63:0] wake_pin,
  input wire logic [63:0] wake_en,
  input wire logic [63:0][2:0] wake_irq_sel,
  input wire logic [63:0] wake_clr,
  input wire logic ext_reset_n_pin,
  input wire logic wdt_trigger,
  input wire logic debug_reset_req,
  output power_mode_e mode,
  output logic hclk_tick,
  output logic pclk_tick,
  output logic [1:0] aux_tick,
  output logic slow_tick,
  output logic timing_watchdog_tick,
  output logic cpu_run,
  output logic hf_osc_en,
  output logic [1:0] pll_en,
  output logic [1:0] pll_locked,
  output logic dev_reset,
  output logic [7:0] wake_irq,
  output logic [63:0] wake_pending
);
  localparam int NPRE = 2 + `CRPM_PLL_N + `CRPM_AUX_N;
  localparam logic [11:0] POR_CNT = 12'(`CRPM_POR_CYCLES);
  localparam logic [4:0] LOCK_CNT = 5'(`CRPM_PLL_LOCK_REF);

  typedef struct packed {
    logic [2:0] xtal_s;
    logic [2:0] ext_s;
    logic [2:0] x32_s;
    logic [1:0] rstpin_s;
    logic [63:0] w0;
    logic [63:0] w1;
    logic [63:0] w2;
    logic [63:0] pend;
    power_mode_e mode;
    logic [1:0] src;
    logic skip;
    logic [1:0][4:0] lock_cnt;
    logic [11:0] por_cnt;
    logic hclk_tick;
    logic slow_tick;
    logic timing_watchdog_tick;
    logic cpu_run;
    logic hf_osc_en;
    logic [1:0] pll_en;
    logic dev_reset;
    logic [7:0] irq;
  } ctl_s;

  ctl_s st;
  ctl_s next_st;
  logic [NPRE-1:0] ptick;
  logic main_tick;
  logic [1:0] pll_tick;
  logic [1:0] locked;
  logic [11:0] pclk_ratio;

  prescale_if pif[NPRE] ();

  // Index 0 slow clock, 1 peripheral clock, 2..3 PLLs, 4..5 auxiliary clocks.
  genvar g;
  generate
    for (g = 0; g < NPRE; g++) begin : g_pre
      tick_prescaler u_pre (
        .clk(clk),
        .rst(rst),
        .p(pif[g])
      );
      assign ptick[g] = pif[g].tick_out;
    end
  endgenerate

  function automatic logic pick(input logic [1:0] s, input logic m, input logic [1:0] p);
    unique case (s)
      `CRPM_SRC_PLL0: pick = p[0];
      `CRPM_SRC_PLL1: pick = p[1];
      default: pick = m;
    endcase
  endfunction

  assign main_tick = st.hf_osc_en & (main_src_ext ? (st.ext_s[1] & ~st.ext_s[2]) :
                                     (st.xtal_s[1] & ~st.xtal_s[2]));
  assign locked[0] = st.lock_cnt[0] == LOCK_CNT;
  assign locked[1] = st.lock_cnt[1] == LOCK_CNT;
  assign pll_tick = ptick[3:2] & locked;

  always_comb begin
    unique case (pclk_div)
      `CRPM_PCLK_DIV2: pclk_ratio = `CRPM_RATIO_DIV2;
      `CRPM_PCLK_DIV4: pclk_ratio = `CRPM_RATIO_DIV4;
      default: pclk_ratio = `CRPM_RATIO_DIV1;
    endcase
  end

  assign pif[0].tick_in = main_tick;
  assign pif[0].ratio = slow_ratio;
  assign pif[1].tick_in = st.hclk_tick;
  assign pif[1].ratio = pclk_ratio;
  assign pif[2].tick_in = st.pll_en[0];
  assign pif[2].ratio = pll_ratio[0];
  assign pif[3].tick_in = st.pll_en[1];
  assign pif[3].ratio = pll_ratio[1];
  assign pif[4].tick_in = pick(aux_src[0], main_tick, pll_tick) & (st.mode == ACTIVE);
  assign pif[4].ratio = aux_ratio[0];
  assign pif[5].tick_in = pick(aux_src[1], main_tick, pll_tick) & (st.mode == ACTIVE);
  assign pif[5].ratio = aux_ratio[1];

  always_comb begin
    logic slow_c;
    logic old_t;
    logic old_alive;
    logic fast_c;
    logic [63:0] rise;
    slow_c = 1'b0;
    old_t = 1'b0;
    old_alive = 1'b0;
    fast_c = 1'b0;
    rise = '0;
    next_st = st;
    next_st.xtal_s = {st.xtal_s[1:0], xtal_clk_pin};
    next_st.ext_s = {st.ext_s[1:0], ext_clk_pin};
    next_st.x32_s = {st.x32_s[1:0], x32_pin};
    next_st.rstpin_s = {st.rstpin_s[0], ext_reset_n_pin};
    next_st.w0 = wake_pin;
    next_st.w1 = st.w0;
    next_st.w2 = st.w1;

    slow_c = slow_src_presc ? ptick[0] : (st.x32_s[1] & ~st.x32_s[2]);

    for (int i = 0; i < `CRPM_PLL_N; i++) begin
      if (!st.pll_en[i]) begin
        next_st.lock_cnt[i] = '0;
      end else if (main_tick && !locked[i]) begin
        next_st.lock_cnt[i] = st.lock_cnt[i] + 1'b1;
      end
    end

    // The old source must finish its period and the new one start a fresh one.
    old_t = pick(st.src, main_tick, pll_tick);
    old_alive = pick(st.src, st.hf_osc_en, locked);
    if (st.skip) begin
      next_st.skip = ~old_t;
    end else if (hclk_src != st.src && (old_t || !old_alive)) begin
      next_st.src = hclk_src;
      next_st.skip = 1'b1;
    end else begin
      fast_c = old_t;
    end

    // Set wins over a clear landing in the same cycle.
    rise = st.w1 & ~st.w2;
    next_st.pend = (st.pend & ~wake_clr) | (rise & wake_en);
    next_st.irq = '0;
    for (int c = 0; c < `CRPM_WAKE_N; c++) begin
      for (int k = 0; k < `CRPM_WAKE_IRQ_N; k++) begin
        if (st.pend[c] && wake_irq_sel[c] == 3'(k)) begin
          next_st.irq[k] = 1'b1;
        end
      end
    end

    if (st.por_cnt != POR_CNT) begin
      next_st.por_cnt = st.por_cnt + 1'b1;
    end
    next_st.dev_reset = (st.por_cnt != POR_CNT) | ~st.rstpin_s[1] |
                        wdt_trigger | debug_reset_req;

    if (st.dev_reset) begin
      next_st.mode = ACTIVE;
    end else if (st.mode != ACTIVE && |st.pend) begin
      next_st.mode = ACTIVE;
    end else if (mode_req_stb) begin
      next_st.mode = mode_req;
    end

    unique case (st.mode)
      ACTIVE: next_st.hclk_tick = fast_c;
      POWER_SAVE: next_st.hclk_tick = slow_c;
      default: next_st.hclk_tick = 1'b0;
    endcase
    next_st.slow_tick = slow_c;
    next_st.timing_watchdog_tick = slow_c & (st.mode != HALT);
    next_st.cpu_run = (next_st.mode == ACTIVE) || (next_st.mode == POWER_SAVE);
    // The fast oscillator may only stop when the slow clock does not depend on it.
    next_st.hf_osc_en = ~((next_st.mode != ACTIVE) & ~slow_src_presc & hf_off_req);
    next_st.pll_en = pll_req & {2{next_st.hf_osc_en}};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.rstpin_s <= 2'h3;
      st.hf_osc_en <= 1'b1;
      st.dev_reset <= 1'b1;
      st.cpu_run <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign mode = st.mode;
  assign hclk_tick = st.hclk_tick;
  assign pclk_tick = ptick[1];
  assign aux_tick = ptick[5:4];
  assign slow_tick = st.slow_tick;
  assign timing_watchdog_tick = st.timing_watchdog_tick;
  assign cpu_run = st.cpu_run;
  assign hf_osc_en = st.hf_osc_en;
  assign pll_en = st.pll_en;
  assign pll_locked = locked;
  assign dev_reset = st.dev_reset;
  assign wake_irq = st.irq;
  assign wake_pending = st.pend;

  property p_wdt_reset;
    @(posedge clk) disable iff (rst) wdt_trigger |=> dev_reset;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog did not reset");

  property p_por_hold;
    @(posedge clk) rst ##1 !rst |-> dev_reset [*8];
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("power-on reset too short");

  property p_ps_hclk;
    @(posedge clk) disable iff (rst) $past(mode) == POWER_SAVE |-> hclk_tick == slow_tick;
  endproperty
  a_ps_hclk: assert property (p_ps_hclk) else $error("power save core clock not slow");

  property p_idle_stop;
    @(posedge clk) disable iff (rst) mode == IDLE |-> !cpu_run ##1 !hclk_tick;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("idle mode still clocks");

  property p_halt_stop;
    @(posedge clk) disable iff (rst) mode == HALT |=> !hclk_tick && !timing_watchdog_tick;
  endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("halt mode still clocks");

  property p_wake;
    @(posedge clk) disable iff (rst)
      (mode != ACTIVE && wake_pending != 64'h0) |=> mode == ACTIVE;
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up did not return to active");

  property p_wake_irq;
    @(posedge clk) disable iff (rst) $past(wake_pending[5] && wake_irq_sel[5] == 3'h3) |->
      wake_irq[3];
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake-up interrupt not routed");

  property p_osc_off;
    @(posedge clk) disable iff (rst) !hf_osc_en |-> mode != ACTIVE && pll_en == 2'h0;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("fast clocks stopped in active");
endmodule

/* File: common/crpm_defs.svh */
// Constants for the clock, reset and power-mode controller.
`ifndef CRPM_DEFS_SVH
`define CRPM_DEFS_SVH
`define CRPM_CLK_PERIOD_NS 5
`define CRPM_MAIN_CLK_KHZ 12000
`define CRPM_PRESC_W 12
`define CRPM_WAKE_N 64
`define CRPM_WAKE_IRQ_N 8
`define CRPM_AUX_N 2
`define CRPM_PLL_N 2
`define CRPM_POR_TIME_NS 10000
`define CRPM_POR_CYCLES ((`CRPM_POR_TIME_NS + `CRPM_CLK_PERIOD_NS - 1) / `CRPM_CLK_PERIOD_NS)
`define CRPM_PLL_LOCK_REF 16
`define CRPM_SRC_MAIN 2'h0
`define CRPM_SRC_PLL0 2'h1
`define CRPM_SRC_PLL1 2'h2
`define CRPM_PCLK_DIV1 2'h0
`define CRPM_PCLK_DIV2 2'h1
`define CRPM_PCLK_DIV4 2'h2
`define CRPM_RATIO_DIV1 12'h000
`define CRPM_RATIO_DIV2 12'h001
`define CRPM_RATIO_DIV4 12'h003
`endif

/* File: common/crpm_pkg.sv */
// Types shared by the clock, reset and power-mode controller.
package crpm_pkg;
  typedef enum logic [1:0] {
    ACTIVE,
    POWER_SAVE,
    IDLE,
    HALT
  } power_mode_e;
endpackage

/* File: common/prescale_if.sv */
// Carrier between the controller and one tick prescaler.
`timescale 1ns/1ps
`include "crpm_defs.svh"
interface prescale_if;
  logic tick_in;
  logic [`CRPM_PRESC_W-1:0] ratio;
  logic tick_out;
  modport owner (output tick_in, output ratio, input tick_out);
  modport divider (input tick_in, input ratio, output tick_out);
endinterface

/* File: rtl/tick_prescaler.sv */
// Programmable divider of a tick stream by ratio plus one.
`timescale 1ns/1ps
`include "crpm_defs.svh"
module tick_prescaler (
  input wire logic clk,
  input wire logic rst,
  prescale_if.divider p
);
  typedef struct packed {
    logic [`CRPM_PRESC_W-1:0] cnt;
    logic [`CRPM_PRESC_W-1:0] ratio_q;
    logic out;
  } presc_s;

  presc_s st;
  presc_s next_st;

  always_comb begin
    next_st = st;
    next_st.out = 1'b0;
    if (p.tick_in) begin
      if (st.cnt >= st.ratio_q) begin
        next_st.out = 1'b1;
        next_st.cnt = '0;
        // A new ratio is taken only at a period boundary, so no short period can appear.
        next_st.ratio_q = p.ratio;
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign p.tick_out = st.out;
endmodule

/* File: dv/osc_model.sv */
// Model of the oscillators, reset pin and wake sources around the clock controller.
`timescale 1ns/1ps
module osc_model (
  input wire logic hold_reset,
  input wire logic [63:0] wake_drive,
  output logic xtal_clk_pin,
  output logic ext_clk_pin,
  output logic x32_pin,
  output logic ext_reset_n_pin,
  output logic [63:0] wake_pin
);
  // Both fast sources run free; the offset makes a source switch land mid-period.
  initial begin
    xtal_clk_pin = 1'b0;
    forever #41.667 xtal_clk_pin = ~xtal_clk_pin;
  end
  initial begin
    ext_clk_pin = 1'b0;
    #13;
    forever #41.667 ext_clk_pin = ~ext_clk_pin;
  end
  initial begin
    x32_pin = 1'b0;
    forever #15258.789 x32_pin = ~x32_pin;
  end
  assign ext_reset_n_pin = ~hold_reset;
  assign wake_pin = wake_drive;
endmodule

/* File: dv/clock_reset_power_modes_bench.sv */
// Self-checking bench for the clock, reset and power-mode controller.
`timescale 1ns/1ps
`define CHK(a, e, m) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch at %0t: %s", $time, m); end end
module clock_reset_power_modes_bench;
  import crpm_pkg::*;
  logic clk, rst, main_src_ext, slow_src_presc, mode_req_stb, hf_off_req, hold_reset;
  logic wdt_trigger, debug_reset_req, xtal_clk_pin, ext_clk_pin, x32_pin, ext_reset_n_pin;
  logic hclk_tick, pclk_tick, slow_tick, timing_watchdog_tick, cpu_run, hf_osc_en, dev_reset;
  logic [11:0] slow_ratio;
  logic [1:0] hclk_src, pll_req, pclk_div, aux_tick, pll_en, pll_locked;
  logic [1:0][11:0] pll_ratio, aux_ratio;
  logic [1:0][1:0] aux_src;
  power_mode_e mode_req, mode;
  logic [63:0] wake_en, wake_clr, wake_drive, wake_pin, wake_pending;
  logic [63:0][2:0] wake_irq_sel;
  logic [7:0] wake_irq;
  int n_fail = 0, checks_done = 0, hc, pc, a0, a1, sc, tc, k, mg, lg;
  int exp_p[3] = '{60, 30, 15};

  always #2.5 clk = ~clk;

  osc_model far (.hold_reset, .wake_drive, .xtal_clk_pin, .ext_clk_pin, .x32_pin,
    .ext_reset_n_pin, .wake_pin);
  clock_reset_power_modes uut (.clk, .rst, .xtal_clk_pin, .ext_clk_pin, .main_src_ext,
    .x32_pin, .slow_src_presc, .slow_ratio, .hclk_src, .pll_req, .pll_ratio, .pclk_div,
    .aux_src, .aux_ratio, .hf_off_req, .mode_req, .mode_req_stb, .wake_pin, .wake_en,
    .wake_irq_sel, .wake_clr, .ext_reset_n_pin, .wdt_trigger, .debug_reset_req, .mode,
    .hclk_tick, .pclk_tick, .aux_tick, .slow_tick, .timing_watchdog_tick, .cpu_run,
    .hf_osc_en, .pll_en, .pll_locked, .dev_reset, .wake_irq, .wake_pending);

  // Counts one-cycle ticks over a window, sampled once each edge's updates have landed.
  task automatic run(input int n);
    hc = 0; pc = 0; a0 = 0; a1 = 0; sc = 0; tc = 0;
    // The smallest spacing of core ticks shows a short period left by a source switch.
    mg = 1000; lg = 1000;
    repeat (n) begin
      @(posedge clk);
      #1;
      hc += hclk_tick; pc += pclk_tick; a0 += aux_tick[0]; a1 += aux_tick[1];
      sc += slow_tick; tc += timing_watchdog_tick;
      mg = (hclk_tick === 1'b1 && lg < mg) ? lg : mg;
      lg = (hclk_tick === 1'b1) ? 1 : lg + 1;
    end
  endtask

  task automatic set_mode(input power_mode_e m);
    @(posedge clk);
    mode_req <= m;
    mode_req_stb <= 1'b1;
    @(posedge clk);
    mode_req_stb <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(mode, m, "mode change")
  endtask

  // Reset release may include what is left of the power-on span, so the wait is bounded well above it.
  task automatic wait_reset_low;
    k = 0;
    while (dev_reset !== 1'b0 && k < 3000) begin
      @(posedge clk);
      #1;
      k++;
    end
    `CHK(dev_reset, 1'b0, "reset release")
  endtask

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    stop_test();
  end

  initial begin
    clk = 1'b0; rst = 1'b1; main_src_ext = 1'b0; slow_src_presc = 1'b1; slow_ratio = 12'h009;
    hclk_src = 2'h0; pll_req = 2'h0; pll_ratio = '0; pclk_div = 2'h0; aux_src = '0;
    aux_ratio = '0; hf_off_req = 1'b0; mode_req = ACTIVE; mode_req_stb = 1'b0;
    wake_en = '0; wake_irq_sel = '0; wake_clr = '0; wake_drive = '0; hold_reset = 1'b0;
    wdt_trigger = 1'b0; debug_reset_req = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    run(1);
    `CHK({dev_reset, mode, cpu_run, hf_osc_en}, {1'b1, ACTIVE, 2'b11}, "reset state")
    `CHK(wake_pending, 64'h0, "pending at reset")
    run(1900);
    `CHK(dev_reset, 1'b1, "power-on too short")
    wait_reset_low();
    run(1000);
    `CHK(hc inside {[58:62]}, 1'b1, "crystal main rate")
    @(posedge clk) main_src_ext <= 1'b1;
    run(100);
    run(1000);
    `CHK(hc inside {[58:62]}, 1'b1, "external main rate")
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) pclk_div <= 2'(i);
      run(100);
      run(1000);
      `CHK(pc inside {[exp_p[i] - 2:exp_p[i] + 2]}, 1'b1, "peripheral divide")
    end
    @(posedge clk);
    aux_ratio <= {12'h003, 12'h001};
    pll_req <= 2'b11;
    pll_ratio <= {12'h001, 12'h003};
    run(600);
    `CHK({pll_en, pll_locked}, 4'hF, "pll lock")
    run(1000);
    `CHK({a0 inside {[28:32]}, a1 inside {[13:17]}}, 2'b11, "aux prescale")
    @(posedge clk) aux_src <= {2'h2, 2'h1};
    run(100);
    run(1000);
    `CHK({a0 inside {[123:126]}, a1 inside {[123:126]}}, 2'b11, "aux from pll")
    @(posedge clk) hclk_src <= 2'h1;
    run(100);
    `CHK(mg >= 4, 1'b1, "glitch-free switch to pll")
    run(1000);
    `CHK(hc inside {[245:252]}, 1'b1, "core from pll")
    @(posedge clk) hclk_src <= 2'h0;
    run(100);
    `CHK(mg >= 4, 1'b1, "glitch-free switch to main")
    set_mode(POWER_SAVE);
    `CHK(cpu_run, 1'b1, "cpu in power save")
    run(3000);
    `CHK({sc inside {[16:19]}, hc inside {[sc - 1:sc + 1]}}, 2'b11, "slow core")
    `CHK(tc, sc, "watchdog clock")
    set_mode(IDLE);
    `CHK(cpu_run, 1'b0, "cpu in idle")
    run(3000);
    `CHK({hc == 0, tc inside {[16:19]}}, 2'b11, "idle clocks")
    @(posedge clk);
    wake_en[5] <= 1'b1;
    wake_irq_sel[5] <= 3'h3;
    wake_drive[6:5] <= 2'b11;
    run(8);
    `CHK({wake_pending[6:5], mode}, {2'b01, ACTIVE}, "wake to active")
    `CHK(wake_irq, 8'h08, "wake interrupt line")
    @(posedge clk);
    wake_drive <= '0;
    wake_clr[5] <= 1'b1;
    @(posedge clk) wake_clr[5] <= 1'b0;
    run(2);
    `CHK({wake_pending[5], wake_irq}, 9'h000, "wake clear")
    set_mode(HALT);
    run(3000);
    `CHK({cpu_run, hc == 0, tc == 0}, 3'b011, "halt stops all")
    set_mode(ACTIVE);
    @(posedge clk);
    slow_src_presc <= 1'b0;
    hf_off_req <= 1'b1;
    set_mode(POWER_SAVE);
    run(14000);
    `CHK({hf_osc_en, pll_en, sc inside {[1:3]}}, 4'b0001, "fast side off")
    @(posedge clk) wdt_trigger <= 1'b1;
    run(3);
    `CHK({dev_reset, mode}, {1'b1, ACTIVE}, "watchdog reset")
    @(posedge clk) wdt_trigger <= 1'b0;
    wait_reset_low();
    `CHK(hf_osc_en, 1'b1, "fast osc back")
    @(posedge clk) debug_reset_req <= 1'b1;
    run(2);
    `CHK(dev_reset, 1'b1, "debug reset")
    @(posedge clk) debug_reset_req <= 1'b0;
    wait_reset_low();
    @(posedge clk) hold_reset <= 1'b1;
    run(5);
    `CHK(dev_reset, 1'b1, "pin reset")
    @(posedge clk) hold_reset <= 1'b0;
    wait_reset_low();
    stop_test();
  end
endmodule
